// >>> hw/srcs_slave.sv
// SPI register command slave: command decode, auto-increment, register port
//
// Overview of operation
// - Serial clock idles low between transfers (clock polarity zero).
// - Output shifts on rising serial edge, input sampled on falling edge.
// - First 16-bit word after select falls is always the command word.
// - Every word is exactly sixteen clocks through one shift register.
// - Select rising mid-word drops the partial word; no register is written.
// - Command bit 15 set means read, clear means write.
// - Page in bits 13:12, start address 10:6, end address 4:0.
// - Page 00 is page zero, 01 page one, upper-bit patterns reserved.
// - End not above start accesses only the start register.
// - Range access walks consecutive addresses from start to end.
// - Reads past the end address return all-zero words.
// - Writes past the end address are discarded.
// - Select rising before range end leaves remaining registers untouched.
// - Read cut mid-word stops shifting; master drops the partial word.
// - Master-in output line is released while select is high.
// - No bits are captured unless select is low.
// - Reserved locations read zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none
module srcs_slave
    import srcs_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 5,
    parameter int WQ_DEPTH = FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_srst,
    // Serial pins
    input wire logic i_sclk,
    input wire logic i_mosi,
    input wire logic i_ss_n,
    output logic o_miso,
    output logic o_miso_oe,
    // Register read port: address out, data back in the same cycle
    output logic o_rd_en,
    output logic [1:0] o_rd_page,
    output logic [ADDR_W-1:0] o_rd_addr,
    input wire logic [DATA_W-1:0] i_rd_data,
    // Register write stream, drained through the FIFO
    output logic o_wr_valid,
    input wire logic i_wr_ready,
    output logic [1:0] o_wr_page,
    output logic [ADDR_W-1:0] o_wr_addr,
    output logic [DATA_W-1:0] o_wr_data,
    // Status
    output logic o_busy,
    output logic o_wr_dropped
);
    localparam int QW = 2 + ADDR_W + DATA_W;
    initial begin
        if (DATA_W != WORD_BITS || ADDR_W != ADDR_BITS) begin
            $error("srcs_slave: word and address widths are fixed by the command format");
        end
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic sclk_s;
    logic mosi_s;
    logic ss_n_s;
    srcs_sync #(.INIT(1'b0)) u_sync_sclk (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_async(i_sclk),
        .o_sync(sclk_s)
    );
    srcs_sync #(.INIT(1'b0)) u_sync_mosi (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_async(i_mosi),
        .o_sync(mosi_s)
    );
    // Select resets to its idle level so reset shows no false select edge
    srcs_sync #(.INIT(1'b1)) u_sync_ss (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_async(i_ss_n),
        .o_sync(ss_n_s)
    );

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic sclk_d;
        logic ss_n_d;
        srcs_phase_t phase;
        logic [3:0] bit_cnt;
        logic [DATA_W-1:0] shift;
        logic dir_read;
        logic [1:0] page;
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] end_addr;
        logic load_pend;
        logic rd_en;
        logic miso;
        logic miso_oe;
        logic q_valid;
        logic [QW-1:0] q_data;
        logic dropped;
    } srcs_slave_t;
    srcs_slave_t st;
    srcs_slave_t next_st;

    logic rise;
    logic fall;
    logic sel;
    logic ss_fall;
    logic [DATA_W-1:0] word_in;
    logic q_ready;
    logic page_ok;
    assign rise = sclk_s && !st.sclk_d;
    assign fall = !sclk_s && st.sclk_d;
    assign sel = !ss_n_s;
    assign ss_fall = !ss_n_s && st.ss_n_d;
    assign word_in = {st.shift[DATA_W-2:0], mosi_s};
    assign page_ok = (st.page == PAGE_ZERO) || (st.page == PAGE_ONE);

    srcs_fifo #(.WIDTH(QW), .DEPTH(WQ_DEPTH)) u_wq (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_in_valid(st.q_valid),
        .o_in_ready(q_ready),
        .i_in_data(st.q_data),
        .o_out_valid(o_wr_valid),
        .i_out_ready(i_wr_ready),
        .o_out_data({o_wr_page, o_wr_addr, o_wr_data})
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        next_st.sclk_d = sclk_s;
        next_st.ss_n_d = ss_n_s;
        next_st.rd_en = 1'b0;
        if (st.q_valid && q_ready) begin
            next_st.q_valid = 1'b0;
        end
        // read data lands one cycle after the address is issued
        if (st.rd_en) begin
            next_st.shift = page_ok ? i_rd_data : ZERO_WORD;
            next_st.miso = page_ok ? i_rd_data[DATA_W-1] : 1'b0;
        end
        if (!sel) begin
            // select high aborts any word and operation
            next_st.phase = PH_IDLE;
            next_st.bit_cnt = BIT_CNT_RESET;
            next_st.load_pend = 1'b0;
            next_st.miso_oe = 1'b0;
            next_st.miso = 1'b0;
        end else begin
            next_st.miso_oe = 1'b1;
            // a falling select always starts a command word
            if (ss_fall) begin
                next_st.phase = PH_COMMAND;
                next_st.bit_cnt = BIT_CNT_RESET;
                next_st.shift = ZERO_WORD;
                next_st.miso = 1'b0;
            end else if (rise && st.phase != PH_IDLE) begin
                // shift out on rising edge; first bit already on the line
                if (st.bit_cnt != BIT_CNT_RESET) begin
                    next_st.miso = st.shift[DATA_W-1];
                end
            end else if (fall && st.phase != PH_IDLE) begin
                // sample input on falling edge, sixteen per word
                next_st.shift = word_in;
                next_st.bit_cnt = st.bit_cnt + 4'h1;
                if (st.bit_cnt == BIT_CNT_LAST) begin
                    next_st.bit_cnt = BIT_CNT_RESET;
                    unique case (st.phase)
                        PH_COMMAND: begin
                            next_st.dir_read = word_in[DIR_BIT];
                            next_st.page = word_in[PAGE_HI_BIT:PAGE_LO_BIT];
                            next_st.addr = word_in[START_HI_BIT:START_LO_BIT];
                            // end not above start collapses to one register
                            if (word_in[END_HI_BIT:END_LO_BIT] <= word_in[START_HI_BIT:START_LO_BIT]) begin
                                next_st.end_addr = word_in[START_HI_BIT:START_LO_BIT];
                            end else begin
                                next_st.end_addr = word_in[END_HI_BIT:END_LO_BIT];
                            end
                            next_st.phase = PH_DATA;
                            next_st.load_pend = word_in[DIR_BIT];
                        end
                        PH_DATA: begin
                            if (!st.dir_read) begin
                                if (page_ok) begin
                                    if (st.q_valid && !q_ready) begin
                                        next_st.dropped = 1'b1;
                                    end else begin
                                        next_st.q_valid = 1'b1;
                                        next_st.q_data = {st.page, st.addr, word_in};
                                    end
                                end
                            end
                            if (st.addr == st.end_addr) begin
                                next_st.phase = PH_DRAIN;
                                next_st.shift = ZERO_WORD;
                                next_st.miso = 1'b0;
                            end else begin
                                next_st.addr = st.addr + 1'b1;
                                next_st.load_pend = st.dir_read;
                            end
                        end
                        // words past the end change nothing
                        PH_DRAIN: begin
                            next_st.shift = ZERO_WORD;
                        end
                        PH_IDLE: begin
                        end
                    endcase
                end
            end
            // fetch before the next rising edge
            if (st.load_pend && !ss_fall) begin
                next_st.load_pend = 1'b0;
                next_st.rd_en = 1'b1;
            end
        end
        if (i_srst) begin
            next_st = '0;
            next_st.ss_n_d = 1'b1;
            next_st.phase = PH_IDLE;
        end
    end

    always_ff @(posedge i_clk) begin
        st <= next_st;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign o_miso = st.miso;
    assign o_miso_oe = st.miso_oe;
    assign o_rd_en = st.rd_en;
    assign o_rd_page = st.page;
    assign o_rd_addr = st.addr;
    assign o_busy = st.phase != PH_IDLE;
    assign o_wr_dropped = st.dropped;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_miso_release: assert property (@(posedge i_clk) disable iff (i_srst)
        !sel |=> !o_miso_oe)
        else $error("output line driven while deselected");
    chk_abort_idle: assert property (@(posedge i_clk) disable iff (i_srst)
        !sel |=> st.phase == PH_IDLE && st.bit_cnt == BIT_CNT_RESET)
        else $error("partial word survived deselect");
    chk_cmd_first: assert property (@(posedge i_clk) disable iff (i_srst)
        ss_fall |=> st.phase == PH_COMMAND)
        else $error("select fall did not start a command");
    chk_write_push: assert property (@(posedge i_clk) disable iff (i_srst)
        $rose(st.q_valid) |-> $past(st.phase) == PH_DATA && !st.dir_read)
        else $error("write queued outside data phase");
    chk_reserved_page: assert property (@(posedge i_clk) disable iff (i_srst)
        $rose(st.q_valid) |-> st.q_data[QW-1] == 1'b0)
        else $error("write to reserved page queued");
    chk_read_fetch: assert property (@(posedge i_clk) disable iff (i_srst)
        o_rd_en |-> st.dir_read && st.phase == PH_DATA)
        else $error("fetch outside read data phase");
    chk_range_end: assert property (@(posedge i_clk) disable iff (i_srst)
        st.phase == PH_DATA |-> st.addr <= st.end_addr)
        else $error("address passed end of range");
    chk_drain_zero: assert property (@(posedge i_clk) disable iff (i_srst)
        st.phase == PH_DRAIN |-> o_miso == 1'b0)
        else $error("nonzero data after range end");

    // ****************************************************************
    // Bit counting, framing and fetch checks
    // ****************************************************************
    chk_miso_drive: assert property (@(posedge i_clk) disable iff (i_srst)
        sel |=> o_miso_oe)
        else $error("output line not driven while selected");
    chk_cmd_silent: assert property (@(posedge i_clk) disable iff (i_srst)
        st.phase == PH_COMMAND |-> !o_miso)
        else $error("data shifted out during command word");
    chk_no_capture: assert property (@(posedge i_clk) disable iff (i_srst)
        !sel && !st.rd_en |=> $stable(st.shift))
        else $error("shift register moved while deselected");
    chk_cut_no_write: assert property (@(posedge i_clk) disable iff (i_srst)
        !sel |=> !$rose(st.q_valid))
        else $error("write queued after deselect");
    chk_idle_no_fetch: assert property (@(posedge i_clk) disable iff (i_srst)
        !sel |=> !o_rd_en && !st.load_pend)
        else $error("fetch pending after deselect");
    chk_bit_step: assert property (@(posedge i_clk) disable iff (i_srst)
        sel && !ss_fall && fall && st.phase != PH_IDLE |=> st.bit_cnt == $past(st.bit_cnt) + 4'h1)
        else $error("bit count did not step on falling edge");
    chk_bit_hold: assert property (@(posedge i_clk) disable iff (i_srst)
        sel && !ss_fall && !fall |=> $stable(st.bit_cnt))
        else $error("bit count moved without falling edge");
    chk_fetch_once: assert property (@(posedge i_clk) disable iff (i_srst)
        o_rd_en |=> !o_rd_en)
        else $error("fetch pulse longer than one cycle");
    chk_busy_select: assert property (@(posedge i_clk) disable iff (i_srst)
        !sel |=> !o_busy)
        else $error("busy while deselected");

    // ****************************************************************
    // Range, page and write queue checks
    // ****************************************************************
    chk_addr_step: assert property (@(posedge i_clk) disable iff (i_srst)
        $past(st.phase) == PH_DATA && st.phase == PH_DATA && !$stable(st.addr) |-> st.addr == $past(st.addr) + 5'h01)
        else $error("address skipped within range");
    chk_decode_addr: assert property (@(posedge i_clk) disable iff (i_srst)
        $past(st.phase) == PH_COMMAND && st.phase == PH_DATA |-> st.addr == $past(word_in[START_HI_BIT:START_LO_BIT]))
        else $error("start address not taken from command");
    chk_page_hold: assert property (@(posedge i_clk) disable iff (i_srst)
        $past(st.phase) == PH_DATA && st.phase == PH_DATA |-> $stable(st.page) && $stable(st.dir_read))
        else $error("page or direction changed within operation");
    chk_drain_hold: assert property (@(posedge i_clk) disable iff (i_srst)
        st.phase == PH_DRAIN && sel |=> st.phase == PH_DRAIN)
        else $error("left drain while selected");
    chk_drain_no_write: assert property (@(posedge i_clk) disable iff (i_srst)
        st.phase == PH_DRAIN |=> !$rose(st.q_valid))
        else $error("write queued past end of range");
    chk_read_no_queue: assert property (@(posedge i_clk) disable iff (i_srst)
        st.dir_read |=> !$rose(st.q_valid))
        else $error("write queued during read");
    chk_write_addr: assert property (@(posedge i_clk) disable iff (i_srst)
        $rose(st.q_valid) |-> st.q_data[DATA_W +: ADDR_W] == $past(st.addr))
        else $error("queued write carries wrong address");
    chk_read_load: assert property (@(posedge i_clk) disable iff (i_srst)
        st.rd_en && page_ok && !ss_fall && !fall |=> st.shift == $past(i_rd_data))
        else $error("read data not loaded into shift register");
    chk_reserved_read: assert property (@(posedge i_clk) disable iff (i_srst)
        st.rd_en && !page_ok && !ss_fall && !fall && !rise |=> st.shift == ZERO_WORD && !o_miso)
        else $error("reserved page read not zero");
endmodule : srcs_slave
`default_nettype wire

// >>> common/srcs_pkg.sv
// Package: constants and types for the SPI register command slave
package srcs_pkg;
    // ****************************************************************
    // Word and command layout
    // ****************************************************************
    localparam int WORD_BITS = 16;
    localparam int ADDR_BITS = 5;
    localparam int DIR_BIT = 15;
    localparam int PAGE_HI_BIT = 13;
    localparam int PAGE_LO_BIT = 12;
    localparam int START_HI_BIT = 10;
    localparam int START_LO_BIT = 6;
    localparam int END_HI_BIT = 4;
    localparam int END_LO_BIT = 0;
    localparam logic [1:0] PAGE_ZERO = 2'h0;
    localparam logic [1:0] PAGE_ONE = 2'h1;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    localparam logic [3:0] BIT_CNT_LAST = 4'hf;
    // ****************************************************************
    // Timing and write queue depth
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_PERIOD_NS = 160;
    localparam int FIFO_DEPTH = 8;
    // ****************************************************************
    // Transaction phases
    // ****************************************************************
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_COMMAND,
        PH_DATA,
        PH_DRAIN
    } srcs_phase_t;
endpackage : srcs_pkg

// >>> hw/srcs_sync.sv
// Two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module srcs_sync #(
    parameter logic INIT = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_async,
    output logic o_sync
);
    typedef struct packed {
        logic meta;
        logic sync;
    } srcs_sync_t;
    srcs_sync_t st;
    srcs_sync_t next_st;
    always_comb begin
        next_st.meta = i_async;
        next_st.sync = st.meta;
        if (i_srst) begin
            next_st.meta = INIT;
            next_st.sync = INIT;
        end
    end
    always_ff @(posedge i_clk) begin
        st <= next_st;
    end
    assign o_sync = st.sync;
endmodule : srcs_sync
`default_nettype wire

// >>> hw/srcs_fifo.sv
// Small valid/ready FIFO with registered read data
`timescale 1ns/10ps
`default_nettype none
module srcs_fifo #(
    parameter int WIDTH = 23,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("srcs_fifo: DEPTH must be a power of two >= 2");
        end
    end
    logic [WIDTH-1:0] mem [DEPTH];
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
        logic valid;
        logic [WIDTH-1:0] data;
    } srcs_fifo_t;
    srcs_fifo_t st;
    srcs_fifo_t next_st;
    logic full;
    logic stored;
    logic push;
    logic pop;
    assign full = (st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]);
    assign stored = st.wr != st.rd;
    assign push = i_in_valid && !full;
    assign pop = stored && (!st.valid || i_out_ready);
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr = st.wr + 1'b1;
        end
        if (st.valid && i_out_ready) begin
            next_st.valid = 1'b0;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
            next_st.valid = 1'b1;
            next_st.data = mem[st.rd[AW-1:0]];
        end
        if (i_srst) begin
            next_st = '0;
        end
    end
    always_ff @(posedge i_clk) begin
        st <= next_st;
        if (push) begin
            mem[st.wr[AW-1:0]] <= i_in_data;
        end
    end
    assign o_in_ready = !full;
    assign o_out_valid = st.valid;
    assign o_out_data = st.data;
    chk_no_overflow: assert property (@(posedge i_clk) disable iff (i_srst)
        full |=> st.wr == $past(st.wr))
        else $error("FIFO pointer moved while full");
    chk_out_hold: assert property (@(posedge i_clk) disable iff (i_srst)
        st.valid && !i_out_ready |=> st.valid && $stable(st.data))
        else $error("queued entry changed before it was taken");
endmodule : srcs_fifo
`default_nettype wire

// >>> dv/srcs_host.sv
// Serial master model that drives select, clock and data toward the slave
`timescale 1ns/10ps
`default_nettype none
module srcs_host (
    input wire logic i_clk,
    input wire logic i_miso,
    input wire logic i_miso_oe,
    output logic o_sclk,
    output logic o_mosi,
    output logic o_ss_n
);
    initial begin
        o_sclk = 1'b0;
        o_mosi = 1'b0;
        o_ss_n = 1'b1;
    end
    // ****************************************************************
    // Framing
    // ****************************************************************
    task automatic sel();
        @(posedge i_clk);
        o_ss_n <= 1'b0;
        repeat (8) @(posedge i_clk);
    endtask : sel
    // select release
    // Released data line shows the inverse of its last bit, clock idles low
    task automatic desel();
        @(posedge i_clk);
        o_ss_n <= 1'b1;
        o_mosi <= ~o_mosi;
        repeat (8) @(posedge i_clk);
    endtask : desel
    // word shifting
    // Shift on the rise, sample on the fall, half period of 8 clocks
    task automatic word(input logic [15:0] tx, input int nb, output logic [15:0] rx);
        rx = 16'h0000;
        for (int i = 15; i > 15 - nb; i--) begin
            @(posedge i_clk);
            o_sclk <= 1'b1;
            o_mosi <= tx[i];
            repeat (8) @(posedge i_clk);
            o_sclk <= 1'b0;
            rx[i] = i_miso;
            repeat (7) @(posedge i_clk);
        end
    endtask : word
endmodule : srcs_host
`default_nettype wire

// >>> dv/srcs_slave_bench.sv
// Self-checking testbench for the serial register command slave
`timescale 1ns/10ps
`default_nettype none
module srcs_slave_bench;
    import srcs_pkg::*;
    logic clk, srst, sclk, mosi, ss_n, miso, miso_oe, rd_en, wr_valid, wr_ready, busy, dropped, ready_en;
    logic [1:0] rd_page, wr_page;
    logic [4:0] rd_addr, wr_addr;
    logic [15:0] rd_data, wr_data;
    logic [3:0] cyc;
    logic [22:0] wq[$];
    int error_cnt = 0;
    int samples_checked = 0;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    srcs_slave dut_u (.i_clk(clk), .i_srst(srst), .i_sclk(sclk), .i_mosi(mosi), .i_ss_n(ss_n),
        .o_miso(miso), .o_miso_oe(miso_oe), .o_rd_en(rd_en), .o_rd_page(rd_page), .o_rd_addr(rd_addr),
        .i_rd_data(rd_data), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr_page(wr_page),
        .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_busy(busy), .o_wr_dropped(dropped));
    srcs_host host_u (.i_clk(clk), .i_miso(miso), .i_miso_oe(miso_oe), .o_sclk(sclk), .o_mosi(mosi),
        .o_ss_n(ss_n));
    // Register bank stand-in: contents made from page and address
    function automatic logic [15:0] reg_val(input logic [1:0] pg, input logic [4:0] ad);
        return {pg, 9'h0a5, ad};
    endfunction : reg_val
    assign rd_data = reg_val(rd_page, rd_addr);
    // Write consumer stalls every other pair of cycles
    always @(posedge clk) begin
        cyc <= cyc + 4'h1;
        wr_ready <= ready_en & cyc[1];
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            wq.push_back({wr_page, wr_addr, wr_data});
        end
    end
    task automatic chk16(input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk16
    task automatic chk23(input logic [22:0] exp, input logic [22:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk23
    task automatic settle();
        for (int i = 0; i < 400 && (busy !== 1'b0 || wr_valid !== 1'b0); i++) @(posedge clk);
        chk16(16'h0000, {14'h0000, busy, wr_valid});
    endtask : settle
    // Read: cnt words from the range, then zeros; a short last word is not compared
    task automatic rd(input string nm, input logic [15:0] cmd, input logic [1:0] pg, input logic [4:0] sa,
        input int cnt, input int tot, input int nbl);
        logic [15:0] rx;
        int nb;
        host_u.sel();
        host_u.word(cmd, 16, rx);
        chk16(16'h0001, {15'h0000, miso_oe});
        for (int i = 0; i < tot; i++) begin
            nb = (i == tot - 1) ? nbl : 16;
            host_u.word(16'h0000, nb, rx);
            if (nb == 16) chk16((i < cnt) ? reg_val(pg, sa + 5'(i)) : 16'h0000, rx);
        end
        host_u.desel();
        settle();
        chk16(16'h0000, {15'h0000, miso_oe});
        $display("Test %s done", nm);
    endtask : rd
    // Write: tot words sent, cnt of them expected at the register port
    task automatic wr(input string nm, input logic [15:0] cmd, input logic [1:0] pg, input logic [4:0] sa,
        input int cnt, input int tot, input int nbl);
        logic [15:0] rx;
        host_u.sel();
        host_u.word(cmd, 16, rx);
        for (int i = 0; i < tot; i++) host_u.word(16'hc350 + 16'(i * 257), (i == tot - 1) ? nbl : 16, rx);
        host_u.desel();
        repeat (20) @(posedge clk);
        chk16({15'h0000, ~ready_en}, {15'h0000, dropped});
        ready_en <= 1'b1;
        settle();
        chk16(16'(cnt), 16'(wq.size()));
        for (int i = 0; i < cnt && i < wq.size(); i++) begin
            chk23({pg, sa + 5'(i), 16'hc350 + 16'(i * 257)}, wq[i]);
        end
        wq.delete();
        $display("Test %s done", nm);
    endtask : wr
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    initial begin
        #400_000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        srst = 1'b1;
        ready_en = 1'b1;
        cyc = 4'h0;
        wr_ready = 1'b0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        chk16(16'h0000, {15'h0000, miso_oe});
        rd("cut_read", 16'h8087, 2'h0, 5'h02, 2, 3, 8);
        rd("single_read", 16'h8000, 2'h0, 5'h00, 1, 2, 16);
        rd("range_read", 16'h8087, 2'h0, 5'h02, 6, 7, 16);
        rd("dont_care_bits", 16'hd8e1, 2'h1, 5'h03, 1, 2, 16);
        rd("reserved_read", 16'ha000, 2'h2, 5'h00, 0, 1, 16);
        wr("range_write", 16'h10c5, 2'h1, 5'h03, 3, 4, 16);
        wr("cut_word", 16'h1000, 2'h1, 5'h00, 0, 1, 8);
        wr("cut_range", 16'h1003, 2'h1, 5'h00, 2, 2, 16);
        wr("reserved_write", 16'h3000, 2'h3, 5'h00, 0, 1, 16);
        ready_en <= 1'b0;
        wr("fill_queue", 16'h101f, 2'h1, 5'h00, 10, 11, 16);
        give_verdict();
    end
endmodule : srcs_slave_bench
`default_nettype wire
